// File: common/actw_defines.svh
// timing constants and field codes for the conversion timing sequencer
`ifndef ACTW_DEFINES_SVH
`define ACTW_DEFINES_SVH

`define ACTW_FREQ_DIV32    3'h0
`define ACTW_FREQ_DIV16    3'h1
`define ACTW_FREQ_DIV2     3'h4
`define ACTW_FREQ_DIV1     3'h5
`define ACTW_VMODE_NORMAL  2'h0

`define ACTW_DIV32_M1      5'h1f
`define ACTW_DIV16_M1      5'h0f
`define ACTW_DIV2_M1       5'h01
`define ACTW_DIV1_M1       5'h00

`define ACTW_STAB_CYC      8'h04
`define ACTW_STAB_CYC_FAST 8'h06
`define ACTW_CONV_CYC_SLOW 8'h40
`define ACTW_CONV_CYC_FAST 8'hb5
`define ACTW_IRQ_CYC       8'h04
`define ACTW_IRQ_SEQ_CUT   8'h03

`endif

// File: common/actw_pkg.sv
// types for the conversion timing sequencer
package actw_pkg;
	typedef enum logic [1:0] {
		ACTW_IDLE = 2'b00,
		ACTW_STAB = 2'b01,
		ACTW_CONV = 2'b10,
		ACTW_IRQD = 2'b11
	} actw_state_e;
endpackage

// File: design/actw_clk_div.sv
// conversion clock enable divider
module actw_clk_div #(
	parameter int W = 5
) (
	input  wire logic         clock,
	input  wire logic         srst,
	input  wire logic         run,
	input  wire logic [W-1:0] divMinusOne,
	output logic              adTick
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q >= divMinusOne) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// divide-by-one yields a tick every system cycle
	assign adTick = run && (cnt_q >= divMinusOne);
endmodule

// File: design/actw_timing_seq.sv
// conversion timing sequencer: stabilization wait, conversion, interrupt delay
`include "actw_defines.svh"
module actw_timing_seq #(
	parameter int DIVW = 5
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       lowSpeedSel,
	input  wire logic [2:0] convClockFreqSel,
	input  wire logic [1:0] voltageModeSel,
	input  wire logic       conversionRun,
	input  wire logic       comparatorEnable,
	input  wire logic       sequentialMode,
	input  wire logic       hwTrigger,
	input  wire logic       skipWait,
	input  wire logic       start,
	output logic            adTick,
	output logic            settingIllegal,
	output logic            stabilizing,
	output logic            converting,
	output logic            convEndIrq,
	output logic            busy,
	output logic [15:0]     lastConvTime
);
	actw_pkg::actw_state_e state_q;
	actw_pkg::actw_state_e state_d;
	logic [7:0]      cnt_q;
	logic [7:0]      cnt_d;
	logic            irq_q;
	logic            irq_d;
	logic [15:0]     tot_q;
	logic [15:0]     tot_d;
	logic [15:0]     time_q;
	logic [15:0]     time_d;
	logic [DIVW-1:0] divM1;
	logic            legal;
	logic            fast;
	logic            undiv;
	logic [7:0]      stabCyc;
	logic [7:0]      convCyc;
	logic [7:0]      irqCyc;
	logic            enabled;
	logic [7:0]      stageLast;
	logic            stab_q;
	logic            stab_d;
	logic            conv_q;
	logic            conv_d;
	logic            busy_q;
	logic            busy_d;

	// decode clock selection; anything else is prohibited
	always_comb begin
		divM1 = DIVW'(`ACTW_DIV32_M1);
		legal = 1'b0;
		if (voltageModeSel == `ACTW_VMODE_NORMAL) begin
			if (!lowSpeedSel && convClockFreqSel == `ACTW_FREQ_DIV32) begin
				divM1 = DIVW'(`ACTW_DIV32_M1);
				legal = 1'b1;
			end else if (!lowSpeedSel && convClockFreqSel == `ACTW_FREQ_DIV16) begin
				divM1 = DIVW'(`ACTW_DIV16_M1);
				legal = 1'b1;
			end else if (lowSpeedSel && convClockFreqSel == `ACTW_FREQ_DIV2) begin
				divM1 = DIVW'(`ACTW_DIV2_M1);
				legal = 1'b1;
			end else if (lowSpeedSel && convClockFreqSel == `ACTW_FREQ_DIV1) begin
				divM1 = DIVW'(`ACTW_DIV1_M1);
				legal = 1'b1;
			end
		end
	end

	assign fast    = lowSpeedSel;
	assign undiv   = fast && convClockFreqSel == `ACTW_FREQ_DIV1;

	// per-setting stage lengths, in conversion clocks
	always_comb begin
		stabCyc = `ACTW_STAB_CYC;
		convCyc = `ACTW_CONV_CYC_SLOW;
		irqCyc  = `ACTW_IRQ_CYC;
		if (undiv) begin
			// the undivided clock needs a longer settle before sampling starts
			stabCyc = `ACTW_STAB_CYC_FAST;
		end
		if (fast) begin
			convCyc = `ACTW_CONV_CYC_FAST;
		end
		if (sequentialMode) begin
			// back-to-back results come sooner in sequential mode
			irqCyc = `ACTW_IRQ_CYC - `ACTW_IRQ_SEQ_CUT;
		end
	end

	assign enabled = conversionRun && comparatorEnable && legal;
	assign settingIllegal = !legal;

	// divider free-runs during a sequence so ticks stay aligned to its start
	actw_clk_div #(
		.W(DIVW)
	) actw_clk_div_inst (
		.clock      (clock),
		.srst       (srst),
		.run        (state_q != actw_pkg::ACTW_IDLE),
		.divMinusOne(divM1),
		.adTick     (adTick)
	);

	// last count of the running stage; compared against the tick counter
	always_comb begin
		stageLast = 8'h00;
		unique case (state_q)
			actw_pkg::ACTW_IDLE: stageLast = 8'h00;
			actw_pkg::ACTW_STAB: stageLast = stabCyc - 8'h01;
			actw_pkg::ACTW_CONV: stageLast = convCyc - 8'h01;
			actw_pkg::ACTW_IRQD: stageLast = irqCyc - 8'h01;
		endcase
	end

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		irq_d   = 1'b0;
		tot_d   = tot_q;
		time_d  = time_q;
		// 16 bits hold the longest sequence, the /32 setting with its wait
		if (state_q != actw_pkg::ACTW_IDLE) begin
			tot_d = tot_q + 16'h0001;
		end
		unique case (state_q)
			actw_pkg::ACTW_IDLE: begin
				if (start && enabled) begin
					cnt_d = 8'h00;
					tot_d = 16'h0000;
					// hardware-triggered follow-on conversions skip the wait only when skipWait is also set
					if (hwTrigger && skipWait) begin
						state_d = actw_pkg::ACTW_CONV;
					end else begin
						state_d = actw_pkg::ACTW_STAB;
					end
				end
			end
			actw_pkg::ACTW_STAB: begin
				if (adTick) begin
					if (cnt_q == stageLast) begin
						cnt_d   = 8'h00;
						state_d = actw_pkg::ACTW_CONV;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
			actw_pkg::ACTW_CONV: begin
				if (adTick) begin
					if (cnt_q == stageLast) begin
						cnt_d   = 8'h00;
						state_d = actw_pkg::ACTW_IRQD;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
			actw_pkg::ACTW_IRQD: begin
				if (adTick) begin
					if (cnt_q == stageLast) begin
						cnt_d   = 8'h00;
						irq_d   = 1'b1;
						time_d  = tot_q + 16'h0001;
						state_d = actw_pkg::ACTW_IDLE;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
			end
		endcase
		// stopping aborts; field changes are only safe afterwards
		if (!conversionRun || !comparatorEnable) begin
			state_d = actw_pkg::ACTW_IDLE;
			cnt_d   = 8'h00;
		end
		// registered so status pins cannot glitch while the state decodes
		stab_d = state_d == actw_pkg::ACTW_STAB;
		conv_d = state_d == actw_pkg::ACTW_CONV;
		busy_d = state_d != actw_pkg::ACTW_IDLE;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= actw_pkg::ACTW_IDLE;
			cnt_q   <= 8'h00;
			irq_q   <= 1'b0;
			tot_q   <= 16'h0000;
			time_q  <= 16'h0000;
			stab_q  <= 1'b0;
			conv_q  <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			irq_q   <= irq_d;
			tot_q   <= tot_d;
			time_q  <= time_d;
			stab_q  <= stab_d;
			conv_q  <= conv_d;
			busy_q  <= busy_d;
		end
	end

	assign stabilizing  = stab_q;
	assign converting   = conv_q;
	assign busy         = busy_q;
	assign convEndIrq   = irq_q;
	assign lastConvTime = time_q;
endmodule

// File: verif/actw_timing_seq_sva.sv
// concurrent checks on the conversion timing sequencer ports
module actw_timing_seq_sva (
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       lowSpeedSel,
	input wire logic [2:0] convClockFreqSel,
	input wire logic [1:0] voltageModeSel,
	input wire logic       conversionRun,
	input wire logic       comparatorEnable,
	input wire logic       hwTrigger,
	input wire logic       skipWait,
	input wire logic       start,
	input wire logic       adTick,
	input wire logic       settingIllegal,
	input wire logic       stabilizing,
	input wire logic       converting,
	input wire logic       convEndIrq,
	input wire logic       busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic ok;
	logic go;
	logic fast;
	assign ok = voltageModeSel == 2'h0 && (lowSpeedSel ? convClockFreqSel inside {3'h4, 3'h5} : convClockFreqSel < 3'h2);
	assign go = start && !busy && ok && conversionRun && comparatorEnable;
	assign fast = lowSpeedSel && convClockFreqSel == 3'h5;
	a_legal_combo: assert property (settingIllegal == !ok)
		else $error("bad illegal flag");
	a_wait_first: assert property (go && !(hwTrigger && skipWait) |=> stabilizing && !converting)
		else $error("no wait");
	a_tick_full: assert property (busy && fast |-> adTick)
		else $error("tick gap");
	a_tick_half: assert property (adTick && lowSpeedSel && convClockFreqSel == 3'h4 |=> !adTick)
		else $error("tick rate");
	a_irq_end: assert property (convEndIrq |-> $past(busy) && !busy ##1 !convEndIrq)
		else $error("irq shape");
	a_stop_abort: assert property (busy && !(conversionRun && comparatorEnable) |=> !busy)
		else $error("no abort");
	a_wait_long: assert property ($rose(stabilizing) && fast |-> stabilizing [*6])
		else $error("wait short");
	a_conv_long: assert property ($rose(converting) |-> converting [*8])
		else $error("conv short");
	c_irq: cover property (convEndIrq);
	c_skip: cover property (go && hwTrigger && skipWait);
	c_abort: cover property (busy && !conversionRun);
endmodule

// File: verif/actw_sw_model.sv
// software side: changes mode fields only while stopped and after a settle gap
module actw_sw_model (
	input wire logic       clock,
	input wire logic [5:0] cfgReq,
	input wire logic       goReq,
	output logic     [5:0] cfg,
	output logic           runEn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cfg = 6'h00;
		runEn = 1'b0;
		forever begin
			@(negedge clock);
			if (cfg !== cfgReq) begin
				runEn = 1'b0;
				repeat (11) @(negedge clock);
				cfg = cfgReq;
			end
			runEn = goReq;
		end
	end
endmodule

// File: verif/actw_timing_seq_bench.sv
// bench for the conversion timing sequencer
module actw_timing_seq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, srst, goReq, runEn, sequentialMode, hwTrigger, skipWait, start;
	logic        adTick, settingIllegal, stabilizing, converting, convEndIrq, busy;
	logic [5:0]  cfgReq, cfg;
	logic [15:0] lastConvTime;
	int          nMismatch, totalChecks;
	actw_sw_model actw_sw_model_inst (.clock, .cfgReq, .goReq, .cfg, .runEn);
	actw_timing_seq actw_timing_seq_inst (.clock, .srst, .lowSpeedSel(cfg[5]), .convClockFreqSel(cfg[4:2]),
		.voltageModeSel(cfg[1:0]), .conversionRun(runEn), .comparatorEnable(runEn), .sequentialMode, .hwTrigger,
		.skipWait, .start, .adTick, .settingIllegal, .stabilizing, .converting, .convEndIrq, .busy, .lastConvTime);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stopTest();
		$display("mismatches=%0d checks=%0d", nMismatch, totalChecks);
		if (nMismatch == 0 && totalChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// a zero expectation marks a refused start: nothing may begin
	task automatic conv(input logic [5:0] c, input logic [2:0] m, input logic [15:0] n);
		int k;
		cfgReq = c;
		{sequentialMode, hwTrigger, skipWait} = m;
		goReq = 1'b1;
		for (k = 0; !(cfg === c && runEn === 1'b1) && k < 50; k++) @(negedge clock);
		check({15'h0, runEn}, 16'h1);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		if (n == 16'h0) begin
			check({14'h0, busy, settingIllegal}, 16'h1);
			return;
		end
		for (k = 0; convEndIrq !== 1'b1 && k < 3000; k++) @(negedge clock);
		check({15'h0, convEndIrq}, 16'h1);
		check(lastConvTime, n);
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#400000;
		nMismatch++;
		stopTest();
	end
	initial begin
		{srst, goReq, sequentialMode, hwTrigger, skipWait, start} = 6'h20;
		cfgReq = 6'h00;
		repeat (5) @(negedge clock);
		srst = 1'b0;
		conv(6'h00, 3'h0, 16'h0900);
		conv(6'h04, 3'h2, 16'h0480);
		conv(6'h30, 3'h0, 16'h017a);
		conv(6'h34, 3'h0, 16'h00bf);
		conv(6'h34, 3'h4, 16'h00bc);
		conv(6'h34, 3'h7, 16'h00b6);
		conv(6'h30, 3'h3, 16'h0172);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		repeat (100) @(negedge clock);
		goReq = 1'b0;
		repeat (3) @(negedge clock);
		check({15'h0, busy}, 16'h0);
		conv(6'h10, 3'h0, 16'h0000);
		conv(6'h01, 3'h0, 16'h0000);
		conv(6'h00, 3'h4, 16'h08a0);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		repeat (20) @(negedge clock);
		srst = 1'b1;
		@(negedge clock);
		srst = 1'b0;
		check({15'h0, busy}, 16'h0);
		check(lastConvTime, 16'h0000);
		conv(6'h34, 3'h0, 16'h00bf);
		stopTest();
	end
endmodule
bind actw_timing_seq actw_timing_seq_sva actw_timing_seq_sva_inst (
	.clock           (clock),
	.srst            (srst),
	.lowSpeedSel     (lowSpeedSel),
	.convClockFreqSel(convClockFreqSel),
	.voltageModeSel  (voltageModeSel),
	.conversionRun   (conversionRun),
	.comparatorEnable(comparatorEnable),
	.hwTrigger       (hwTrigger),
	.skipWait        (skipWait),
	.start           (start),
	.adTick          (adTick),
	.settingIllegal  (settingIllegal),
	.stabilizing     (stabilizing),
	.converting      (converting),
	.convEndIrq      (convEndIrq),
	.busy            (busy)
);
